/* File: pp_accumulator_branch_datapath.sv */
// Accumulator and branch datapath for opcodes 05 through 31 (octal).
// Assumes the decoder holds opcode and fields stable while i_start is high
// and waits for o_done; local memory answers one cycle after o_mem_rd.
//
// Notes on behaviour
// - Nonzero branch taken unless accumulator is 000000
// - Taken branch adds one's complement 6-bit displacement
// - Plus branch taken when sign bit zero
// - Minus branch taken when sign bit one
// - Shift count top bit picks direction
// - Left shift rotates circularly; 00 is none
// - Right shift zero fills; over 17 clears
// - Short XOR touches low six bits only
// - Short AND clears upper twelve bits
// - Selective clear zeroes low bits set in field
// - Short load zero-extends field into accumulator
// - Load complement: complemented field, upper ones
// - Short add zero-extends field, one's complement
// - Short subtract adds ones over complemented field
// - Long load sets field over second word
// - Long add sums 18-bit constant
// - Long AND with 18-bit constant
// - Long XOR with 18-bit constant
// - Pass opcodes take exactly five clocks
// - Direct load zero-extends memory word
// - Direct add zero-extends memory word, adds
module pp_accumulator_branch_datapath
  import pp_datapath_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Decoded instruction
  input wire logic i_start,
  input wire logic [5:0] i_opcode,
  input wire logic [FLD_W-1:0] i_short_field,
  input wire logic [WORD_W-1:0] i_long_field,
  input wire logic [ADDR_W-1:0] i_prog_addr,
  // Local memory read port
  output logic o_mem_rd,
  output logic [FLD_W-1:0] o_mem_addr,
  input wire logic [WORD_W-1:0] i_mem_data,
  // Results
  output logic o_done,
  output logic o_branch_taken,
  output logic [ADDR_W-1:0] o_branch_target,
  output logic [ACC_W-1:0] o_acc
);

  state_t state_q;
  logic [2:0] pass_cnt_q;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic acc_we;
  logic [ADDR_W-1:0] target_q;
  logic taken_q;
  logic done_q;
  logic take;
  logic [ADDR_W-1:0] disp_ext;
  logic [ADDR_W-1:0] branch_sum;
  logic [ACC_W-1:0] add_b;
  logic [ACC_W-1:0] add_sum;
  logic [ACC_W-1:0] const_long;
  logic [ACC_W-1:0] shifted;
  logic [FLD_W-1:0] right_cnt;
  logic is_pass;
  logic is_mem;
  logic immediate_go;

  // Left counts run up to the largest positive field value
  localparam int ROT_MAX = 2 ** (FLD_W - 1);

  assign const_long = {i_short_field, i_long_field};
  assign is_pass = (i_opcode == OP_PASS_0) || (i_opcode == OP_PASS_1) ||
                   (i_opcode == OP_PASS_2) || (i_opcode == OP_PASS_3);
  assign is_mem = (i_opcode == OP_LOAD_DIRECT) || (i_opcode == OP_ADD_DIRECT);
  assign immediate_go = i_start && (state_q == ST_IDLE) && !is_pass && !is_mem;

  pp_ones_comp_adder #(
    .W(ACC_W)
  ) i_acc_adder (
    .i_a(acc_q),
    .i_b(add_b),
    .o_sum(add_sum)
  );

  // Second operand of the shared adder
  always_comb begin
    case (i_opcode)
      OP_ADD_SHORT: add_b = {ZERO_12, i_short_field};
      OP_SUB_SHORT: add_b = {ONES_12, ~i_short_field};
      OP_ADD_LONG: add_b = const_long;
      OP_ADD_DIRECT: add_b = {ZERO_6, i_mem_data};
      default: add_b = ACC_ZERO;
    endcase
  end

  assign right_cnt = ~i_short_field;
  always_comb begin
    shifted = acc_q;
    if (!i_short_field[FLD_W-1]) begin
      shifted = acc_q;
      for (int i = 0; i < ROT_MAX; i++) begin
        if (FLD_W'(i) < i_short_field) begin
          shifted = {shifted[ACC_W-2:0], shifted[ACC_W-1]};
        end
      end
    end else if (right_cnt > 6'(SHIFT_LIMIT)) begin
      shifted = ACC_ZERO;
    end else begin
      shifted = acc_q >> right_cnt;
    end
  end

  // Branch condition
  always_comb begin
    case (i_opcode)
      OP_NONZERO_BRANCH: take = (acc_q != ACC_ZERO);
      OP_PLUS_BRANCH: take = !acc_q[ACC_W-1];
      OP_MINUS_BRANCH: take = acc_q[ACC_W-1];
      default: take = 1'b0;
    endcase
  end

  assign disp_ext = i_short_field[FLD_W-1] ?
                    {{(ADDR_W-FLD_W){1'b1}}, i_short_field} :
                    {{(ADDR_W-FLD_W){1'b0}}, i_short_field};
  pp_ones_comp_adder #(
    .W(ADDR_W)
  ) i_branch_adder (
    .i_a(i_prog_addr),
    .i_b(disp_ext),
    .o_sum(branch_sum)
  );

  // Accumulator next value
  always_comb begin
    acc_d = acc_q;
    acc_we = 1'b0;
    if (immediate_go) begin
      acc_we = 1'b1;
      case (i_opcode)
        OP_SHIFT: acc_d = shifted;
        OP_XOR_SHORT: acc_d = {acc_q[ACC_W-1:FLD_W], acc_q[FLD_W-1:0] ^ i_short_field};
        OP_AND_SHORT: acc_d = {ZERO_12, acc_q[FLD_W-1:0] & i_short_field};
        OP_SEL_CLEAR: acc_d = {acc_q[ACC_W-1:FLD_W], acc_q[FLD_W-1:0] & ~i_short_field};
        OP_LOAD_SHORT: acc_d = {ZERO_12, i_short_field};
        OP_LOAD_COMP_SHORT: acc_d = {ONES_12, ~i_short_field};
        OP_ADD_SHORT: acc_d = add_sum;
        OP_SUB_SHORT: acc_d = add_sum;
        OP_LOAD_LONG: acc_d = const_long;
        OP_ADD_LONG: acc_d = add_sum;
        OP_AND_LONG: acc_d = acc_q & const_long;
        OP_XOR_LONG: acc_d = acc_q ^ const_long;
        default: acc_we = 1'b0;
      endcase
    end else if (state_q == ST_MEM) begin
      acc_we = 1'b1;
      if (i_opcode == OP_LOAD_DIRECT) begin
        acc_d = {ZERO_6, i_mem_data};
      end else begin
        acc_d = add_sum;
      end
    end
  end

  // Accumulator register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_q <= ACC_RESET;
    end else if (i_clk_en && acc_we) begin
      acc_q <= acc_d;
    end
  end

  // Sequencing of multi-cycle opcodes
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      pass_cnt_q <= 3'd0;
    end else if (i_clk_en) begin
      case (state_q)
        ST_IDLE: begin
          if (i_start && is_pass) begin
            state_q <= ST_PASS;
            pass_cnt_q <= 3'd1;
          end else if (i_start && is_mem) begin
            state_q <= ST_MEM;
          end
        end
        ST_PASS: begin
          if (pass_cnt_q == PASS_CNT_LAST) begin
            state_q <= ST_IDLE;
          end else begin
            pass_cnt_q <= pass_cnt_q + 3'd1;
          end
        end
        ST_MEM: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Completion and branch outputs
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      done_q <= 1'b0;
      taken_q <= 1'b0;
      target_q <= PADDR_RESET;
    end else if (i_clk_en) begin
      done_q <= immediate_go || (state_q == ST_MEM) ||
                (state_q == ST_PASS && pass_cnt_q == PASS_CNT_LAST);
      taken_q <= immediate_go && take;
      if (immediate_go && take) begin
        target_q <= branch_sum;
      end else if (immediate_go || (state_q != ST_IDLE)) begin
        target_q <= i_prog_addr;
      end
    end
  end

  assign o_mem_rd = i_start && (state_q == ST_IDLE) && is_mem;
  assign o_mem_addr = i_short_field;
  assign o_done = done_q;
  assign o_branch_taken = taken_q;
  assign o_branch_target = target_q;
  assign o_acc = acc_q;

endmodule // pp_accumulator_branch_datapath

// One's complement adder, instantiated separately for the accumulator and for the branch target
module pp_ones_comp_adder #(
  parameter int W = 18
) (
  // Operands
  input wire logic [W-1:0] i_a,
  input wire logic [W-1:0] i_b,
  // Sum
  output logic [W-1:0] o_sum
);
  logic [W:0] raw;

  // Carry out of the top bit re-enters at bit zero
  assign raw = {1'b0, i_a} + {1'b0, i_b};
  assign o_sum = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};

endmodule // pp_ones_comp_adder

/* File: pp_accumulator_branch_datapath_props.sv */
// Assertions for the accumulator and branch datapath.
// Assumes opcode and fields are held until o_done.
module pp_datapath_checker
  import pp_datapath_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Instruction
  input wire logic i_start,
  input wire logic [5:0] i_opcode,
  input wire logic [FLD_W-1:0] i_short_field,
  // Results
  input wire logic o_mem_rd,
  input wire logic o_done,
  input wire logic o_branch_taken,
  input wire logic [ACC_W-1:0] o_acc
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_xor_low_bits: assert property (
    o_done && $past(i_opcode) == OP_XOR_SHORT |-> (o_acc ^ $past(o_acc)) ==
    {ZERO_12, $past(i_short_field)}) else $error("short xor result wrong");
  chk_and_clears_upper: assert property (
    o_done && $past(i_opcode) == OP_AND_SHORT |-> o_acc ==
    {ZERO_12, $past(o_acc[5:0]) & $past(i_short_field)}) else $error("short and result wrong");
  chk_load_comp_ones: assert property (
    o_done && $past(i_opcode) == OP_LOAD_COMP_SHORT |-> o_acc ==
    {ONES_12, ~$past(i_short_field)}) else $error("load complement result wrong");
  chk_nonzero_taken: assert property (
    o_done && $past(i_opcode) == OP_NONZERO_BRANCH |->
    o_branch_taken == ($past(o_acc) != ACC_ZERO)) else $error("nonzero branch wrong");
  chk_plus_taken: assert property (
    o_done && $past(i_opcode) == OP_PLUS_BRANCH |->
    o_branch_taken == !$past(o_acc[17])) else $error("plus branch wrong");
  chk_minus_taken: assert property (
    o_done && $past(i_opcode) == OP_MINUS_BRANCH |->
    o_branch_taken == $past(o_acc[17])) else $error("minus branch wrong");
  chk_pass_five_clocks: assert property (
    $rose(i_start) && i_opcode inside {OP_PASS_0, OP_PASS_1, OP_PASS_2, OP_PASS_3} |=>
    !o_done [*4] ##1 o_done) else $error("pass length wrong");
  chk_mem_read_done: assert property (
    o_mem_rd |=> !o_done ##1 o_done) else $error("memory op timing wrong");
endmodule // pp_datapath_checker

/* File: pp_accumulator_branch_datapath_test.sv */
// Self-checking bench for the accumulator and branch datapath.
// Assumes a one-cycle i_start pulse with fields held until o_done.
module pp_accumulator_branch_datapath_test
  import pp_datapath_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_sys_rst = 1, i_start = 0;
  logic [5:0] i_opcode = 0, i_short_field = 0, o_mem_addr;
  logic [11:0] i_long_field = 0, o_branch_target;
  logic o_mem_rd, o_done, o_branch_taken;
  logic [17:0] o_acc;
  int errors = 0, n_checks = 0, lat;
  // Memory word is a fixed pattern of its address
  wire logic [11:0] mem_word = {o_mem_addr, ~o_mem_addr};
  always #4 i_clk = ~i_clk;
  pp_accumulator_branch_datapath i_pp_accumulator_branch_datapath (
    .i_clk, .i_sys_rst, .i_clk_en(1'h1), .i_start, .i_opcode, .i_short_field,
    .i_long_field, .i_prog_addr(12'h100), .o_mem_rd, .o_mem_addr,
    .i_mem_data(mem_word), .o_done, .o_branch_taken, .o_branch_target, .o_acc);
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(logic [17:0] seen, logic [17:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(opcode_t op, logic [5:0] d, logic [11:0] m);
    @(posedge i_clk);
    i_opcode <= op;
    i_short_field <= d;
    i_long_field <= m;
    i_start <= 1'h1;
    @(posedge i_clk);
    i_start <= 1'h0;
    lat = 1;
    @(negedge i_clk);
    while (o_done !== 1'h1 && lat < 20) begin
      @(negedge i_clk);
      lat++;
    end
  endtask
  task automatic acc_op(opcode_t op, logic [5:0] d, logic [11:0] m, logic [17:0] e, int l);
    run(op, d, m);
    check(18'(lat), 18'(l));
    check(o_acc, e);
  endtask
  task automatic br_op(opcode_t op, logic [5:0] d, logic t, logic [11:0] tgt);
    run(op, d, 12'h000);
    check(18'(o_branch_taken), 18'(t));
    check(18'(o_branch_target), 18'(tgt));
  endtask
  task automatic test_logic();
    acc_op(OP_LOAD_SHORT, 6'h2A, 12'h000, 18'h0_002A, 1);
    acc_op(OP_LOAD_COMP_SHORT, 6'h0F, 12'h000, 18'h3_FFF0, 1);
    acc_op(OP_LOAD_LONG, 6'h15, 12'hABC, 18'h1_5ABC, 1);
    acc_op(OP_XOR_SHORT, 6'h3F, 12'h000, 18'h1_5A83, 1);
    acc_op(OP_SEL_CLEAR, 6'h01, 12'h000, 18'h1_5A82, 1);
    acc_op(OP_AND_SHORT, 6'h3E, 12'h000, 18'h0_0002, 1);
    acc_op(OP_LOAD_LONG, 6'h3F, 12'hFFF, 18'h3_FFFF, 1);
    acc_op(OP_AND_LONG, 6'h2A, 12'h555, 18'h2_A555, 1);
    acc_op(OP_XOR_LONG, 6'h3F, 12'hFFF, 18'h1_5AAA, 1);
    $display("test logic done");
  endtask
  task automatic test_arith();
    acc_op(OP_LOAD_LONG, 6'h3F, 12'hFFF, 18'h3_FFFF, 1);
    acc_op(OP_ADD_SHORT, 6'h05, 12'h000, 18'h0_0005, 1);
    acc_op(OP_SUB_SHORT, 6'h05, 12'h000, 18'h3_FFFF, 1);
    acc_op(OP_LOAD_LONG, 6'h20, 12'h000, 18'h2_0000, 1);
    acc_op(OP_ADD_LONG, 6'h20, 12'h000, 18'h0_0001, 1);
    acc_op(OP_SUB_SHORT, 6'h02, 12'h000, 18'h3_FFFE, 1);
    $display("test arith done");
  endtask
  task automatic test_shift();
    acc_op(OP_LOAD_LONG, 6'h20, 12'h001, 18'h2_0001, 1);
    acc_op(OP_SHIFT, 6'h01, 12'h000, 18'h0_0003, 1);
    acc_op(OP_SHIFT, 6'h00, 12'h000, 18'h0_0003, 1);
    acc_op(OP_SHIFT, 6'h1F, 12'h000, 18'h0_6000, 1);
    acc_op(OP_SHIFT, 6'h3F, 12'h000, 18'h0_6000, 1);
    acc_op(OP_SHIFT, 6'h3E, 12'h000, 18'h0_3000, 1);
    acc_op(OP_LOAD_LONG, 6'h20, 12'h000, 18'h2_0000, 1);
    acc_op(OP_SHIFT, 6'h2E, 12'h000, 18'h0_0001, 1);
    acc_op(OP_LOAD_LONG, 6'h3F, 12'hFFF, 18'h3_FFFF, 1);
    acc_op(OP_SHIFT, 6'h2D, 12'h000, 18'h0_0000, 1);
    $display("test shift done");
  endtask
  task automatic test_branch();
    br_op(OP_NONZERO_BRANCH, 6'h0E, 1'h0, 12'h100);
    acc_op(OP_LOAD_LONG, 6'h3F, 12'hFFF, 18'h3_FFFF, 1);
    br_op(OP_NONZERO_BRANCH, 6'h20, 1'h1, 12'h0E1);
    br_op(OP_MINUS_BRANCH, 6'h2D, 1'h1, 12'h0EE);
    br_op(OP_PLUS_BRANCH, 6'h2D, 1'h0, 12'h100);
    acc_op(OP_LOAD_SHORT, 6'h01, 12'h000, 18'h0_0001, 1);
    br_op(OP_PLUS_BRANCH, 6'h1F, 1'h1, 12'h11F);
    br_op(OP_MINUS_BRANCH, 6'h0E, 1'h0, 12'h100);
    $display("test branch done");
  endtask
  task automatic test_mem_pass();
    acc_op(OP_LOAD_DIRECT, 6'h05, 12'h000, 18'h0_017A, 2);
    acc_op(OP_ADD_DIRECT, 6'h3F, 12'h000, 18'h0_113A, 2);
    for (int k = 0; k < 4; k++) begin
      acc_op(opcode_t'(6'(OP_PASS_0 + k)), 6'h15, 12'h000, 18'h0_113A, 5);
    end
    $display("test mem pass done");
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    test_logic();
    test_arith();
    test_shift();
    test_branch();
    test_mem_pass();
    complete_run();
  end
  initial begin
    #(8 * 3000);
    errors++;
    complete_run();
  end
endmodule // pp_accumulator_branch_datapath_test
bind pp_accumulator_branch_datapath pp_datapath_checker i_chk (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_start(i_start), .i_opcode(i_opcode),
  .i_short_field(i_short_field), .o_mem_rd(o_mem_rd), .o_done(o_done),
  .o_branch_taken(o_branch_taken), .o_acc(o_acc));

/* File: pp_datapath_pkg.sv */
// Package for the peripheral processor accumulator and branch datapath.
// Assumes one processor clock; opcodes are 6-bit function codes in octal.
package pp_datapath_pkg;
  localparam int ACC_W = 18;
  localparam int FLD_W = 6;
  localparam int WORD_W = 12;
  localparam int UPPER_W = 12;
  localparam int DATA_UPPER_W = 6;
  localparam int SHIFT_LIMIT = 17;
  localparam int CLK_PERIOD_NS = 8;
  // Pass opcodes occupy this many clock periods
  localparam int PASS_PERIODS = 5;
  localparam logic [2:0] PASS_CNT_LAST = 3'(PASS_PERIODS - 1);

  localparam logic [17:0] ACC_RESET = 18'h0_0000;
  localparam logic [17:0] ACC_ZERO = 18'h0_0000;
  localparam logic [5:0] FLD_ZERO = 6'h00;
  localparam logic [5:0] FLD_NO_SHIFT = 6'h3F;
  localparam logic [11:0] ONES_12 = 12'hFFF;
  localparam logic [11:0] ZERO_12 = 12'h000;
  localparam logic [5:0] ZERO_6 = 6'h00;
  localparam logic [11:0] PADDR_RESET = 12'h000;

  typedef enum logic [5:0] {
    OP_NONZERO_BRANCH = 6'o05,
    OP_PLUS_BRANCH = 6'o06,
    OP_MINUS_BRANCH = 6'o07,
    OP_SHIFT = 6'o10,
    OP_XOR_SHORT = 6'o11,
    OP_AND_SHORT = 6'o12,
    OP_SEL_CLEAR = 6'o13,
    OP_LOAD_SHORT = 6'o14,
    OP_LOAD_COMP_SHORT = 6'o15,
    OP_ADD_SHORT = 6'o16,
    OP_SUB_SHORT = 6'o17,
    OP_LOAD_LONG = 6'o20,
    OP_ADD_LONG = 6'o21,
    OP_AND_LONG = 6'o22,
    OP_XOR_LONG = 6'o23,
    OP_PASS_0 = 6'o24,
    OP_PASS_1 = 6'o25,
    OP_PASS_2 = 6'o26,
    OP_PASS_3 = 6'o27,
    OP_LOAD_DIRECT = 6'o30,
    OP_ADD_DIRECT = 6'o31
  } opcode_t;

  typedef enum {ST_IDLE, ST_PASS, ST_MEM} state_t;
endpackage : pp_datapath_pkg
